// ---- shared/host_port_pkg.sv ----
// shared constants and types for the parallel host port, both ends
`default_nettype none
package host_port_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;

   // byte offsets of the host address space
   localparam logic [8:0] OFF_STATUS_LO = 9'h000;
   localparam logic [8:0] OFF_STATUS_HI_CMD = 9'h001;
   localparam logic [8:0] OFF_IOBUF_LO = 9'h004;
   localparam logic [8:0] OFF_IOBUF_HI = 9'h005;
   localparam logic [8:0] OFF_FIFO_LO = 9'h006;
   localparam logic [8:0] OFF_FIFO_HI = 9'h007;
   localparam logic [8:0] OFF_MEM_FIRST = 9'h078;
   localparam logic [8:0] OFF_MEM_LAST = 9'h1ff;

   // recovery times in reference clock cycles at the reference rate
   localparam int REF_CLK_MHZ = 40;
   localparam int SYS_CLK_MHZ = 200;
   localparam int REF_WR_BUF = 4;
   localparam int REF_WR_MEM = 6;
   localparam int REF_RD = 4;
   localparam int REF_CMD_OP = 8;
   localparam int REF_CMD_WR = 4;
   localparam int REF_CMD_AFTER = 8;
   localparam int REF_RD_XFER = 2;

   // least times round up to whole system clock cycles
   function automatic logic [7:0] to_sys(input int ref_cycles);
      return 8'((ref_cycles * SYS_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ);
   endfunction

   localparam logic [7:0] REC_NONE = 8'h00;
   localparam logic [7:0] REC_WR_BUF = to_sys(REF_WR_BUF);
   localparam logic [7:0] REC_WR_MEM = to_sys(REF_WR_MEM);
   localparam logic [7:0] REC_RD = to_sys(REF_RD);
   localparam logic [7:0] REC_CMD_OP = to_sys(REF_CMD_OP);
   localparam logic [7:0] REC_CMD_WR = to_sys(REF_CMD_WR);
   localparam logic [7:0] REC_CMD_AFTER = to_sys(REF_CMD_AFTER);
   localparam logic [7:0] REC_RD_XFER = to_sys(REF_RD_XFER);

   // command word: opcode in the top nibble, target address below
   localparam logic [3:0] OP_READ = 4'h1;
   localparam logic [3:0] OP_WRITE = 4'h2;
   localparam logic [3:0] OP_START = 4'h3;
   localparam logic [3:0] OP_STOP = 4'h4;

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_RUN = 1;
   localparam int ST_SERIAL = 2;
   localparam int ST_TX_LOADED = 3;
   localparam int STH_MODE_LO = 6;
   localparam int STH_MODE_HI = 7;

   // host controller timing, in system cycles
   localparam logic [7:0] HOST_SETUP_CYC = 8'h02;
   localparam logic [7:0] HOST_STROBE_MIN = 8'h08;
   localparam logic [7:0] HOST_RELEASE_MIN = 8'h08;

   // host controller register indices (word index on the bus)
   localparam logic [9:0] AV_IDX_STATUS = 10'h200;
   localparam logic [9:0] AV_IDX_CMD16 = 10'h201;
   localparam int AV_ST_BUSY = 0;
   localparam int AV_ST_WAIT = 1;

   // pin samples seen by the device through its synchronisers
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [8:0] addr;
      logic [7:0] data;
      logic ser_a;
      logic ser_b;
      logic mode_hi;
      logic mode_lo;
   } dev_sample_t;

   // pin samples seen by the host through its synchronisers
   typedef struct packed {
      logic wait_n;
      logic busy;
      logic [7:0] data;
   } host_sample_t;
endpackage
`default_nettype wire

// ---- shared/host_port_if.sv ----
// parallel host bus between the host controller and the device
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic [8:0] addr;
   logic [7:0] host_data;
   logic host_data_oe;
   logic [7:0] dev_data;
   logic dev_data_oe;
   logic [7:0] data_bus;
   logic wait_request_n;
   logic interface_busy;
   logic host_mode_sel_hi;
   logic host_mode_sel_lo;

   // shared data lines; undriven lines float high through pull-ups
   assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);

   modport device(input cs_n, input rd_n, input wr_n, input addr, input data_bus,
                  input host_mode_sel_hi, input host_mode_sel_lo,
                  output dev_data, output dev_data_oe,
                  output wait_request_n, output interface_busy);
   modport host(output cs_n, output rd_n, output wr_n, output addr,
                output host_data, output host_data_oe,
                output host_mode_sel_hi, output host_mode_sel_lo,
                input data_bus, input wait_request_n, input interface_busy);
endinterface
`default_nettype wire

// ---- verilog/host_port_device.sv ----
// device end of the parallel host port: decode, recovery pacing, command access
//
// Implementation choice: the parallel host bus through the host_port_if device modport.
`timescale 1ns/1ps
`default_nettype none
module host_port_device
   import host_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   host_port_if.device bus,
   input wire logic serial_in_first_in,
   input wire logic serial_in_second_in,
   output logic run_out,
   output logic [15:0] tx_word_out,
   output logic tx_valid_out
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HOLD = 4'b0010,
      ST_XFER = 4'b0100,
      ST_SERVE = 4'b1000
   } dev_state_t;

   dev_sample_t raw;
   dev_sample_t s1_r;
   dev_sample_t s2_r;
   dev_sample_t s3_r;
   dev_sample_t pin_r;
   dev_state_t state_r;
   dev_state_t state_nxt;
   logic [7:0] mem [0:511];
   logic [7:0] rec_cnt_r;
   logic [7:0] xfer_cnt_r;
   logic [7:0] read_data_r;
   logic [7:0] ind_buf_r;
   logic [7:0] io_lo_r;
   logic [7:0] io_hi_r;
   logic [7:0] cmd_lo_r;
   logic cmd_phase_r;
   logic [3:0] last_op_r;
   logic run_r;
   logic [15:0] tx_word_r;
   logic tx_valid_r;
   logic tx_loaded_r;
   logic [15:0] rx_shift_r;
   logic oe_r;
   logic strobe_on;
   logic is_write;
   logic go;
   logic mem_read;
   logic serial_level;
   logic [15:0] cmd_word;
   logic [3:0] cmd_op;
   logic [8:0] cmd_addr;
   logic [8:0] cmd_addr_next;
   logic cmd_exec;
   logic [7:0] status_lo;
   logic [7:0] status_hi;

   // memory area test, used by several decoders
   function automatic logic in_mem(input logic [8:0] a);
      return (a >= OFF_MEM_FIRST) && (a <= OFF_MEM_LAST);
   endfunction

   // recovery needed after an access of a given kind
   function automatic logic [7:0] recovery(input logic wr, input logic [8:0] a,
                                           input logic phase, input logic [3:0] op);
      logic [7:0] r;
      r = REC_NONE;
      if (wr) begin
         if (a == OFF_STATUS_HI_CMD) begin
            if (!phase)
               r = REC_CMD_WR;
            else if (op == OP_READ || op == OP_WRITE)
               r = REC_CMD_AFTER;
            else
               r = REC_CMD_OP;
         end else if (a >= OFF_IOBUF_LO && a <= OFF_FIFO_HI)
            r = REC_WR_BUF;
         else if (in_mem(a))
            r = REC_WR_MEM;
      end else begin
         // io buffer reads recover at once
         if (a == OFF_IOBUF_LO || a == OFF_IOBUF_HI)
            r = REC_NONE;
         else
            r = REC_RD;
      end
      return r;
   endfunction

   // three-stage synchronisers; a change counts once stages two and three agree
   assign raw = {bus.cs_n, bus.rd_n, bus.wr_n, bus.addr, bus.data_bus,
                 serial_in_first_in, serial_in_second_in,
                 bus.host_mode_sel_hi, bus.host_mode_sel_lo};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= '1;
         s2_r <= '1;
         s3_r <= '1;
         pin_r <= '1;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
      end
   end

   // access decode
   assign strobe_on = !pin_r.cs_n && (!pin_r.rd_n || !pin_r.wr_n);
   assign is_write = !pin_r.wr_n;
   assign mem_read = !is_write && in_mem(pin_r.addr);
   assign go = strobe_on && (rec_cnt_r == REC_NONE)
               && (state_r == ST_IDLE || state_r == ST_HOLD);

   // command word assembled from the stored low byte and the incoming high byte
   assign cmd_word = {pin_r.data, cmd_lo_r};
   assign cmd_op = cmd_word[15:12];
   assign cmd_addr = cmd_word[8:0];
   assign cmd_addr_next = 9'(cmd_addr + 9'h001);
   // commands reach past the eight byte window
   assign cmd_exec = go && is_write && (pin_r.addr == OFF_STATUS_HI_CMD) && cmd_phase_r;

   // either serial pin carries the line; an unused one sits low
   assign serial_level = pin_r.ser_a | pin_r.ser_b;

   // next state of the access sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE, ST_HOLD: begin
            if (!strobe_on)
               state_nxt = ST_IDLE;
            else if (go)
               state_nxt = mem_read ? ST_XFER : ST_SERVE;
            else
               state_nxt = ST_HOLD;
         end
         ST_XFER: begin
            if (xfer_cnt_r == REC_NONE)
               state_nxt = ST_SERVE;
         end
         ST_SERVE: begin
            if (!strobe_on)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // recovery counter starts when an access is carried out
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rec_cnt_r <= REC_NONE;
      else if (go)
         rec_cnt_r <= recovery(is_write, pin_r.addr, cmd_phase_r, cmd_op);
      else if (rec_cnt_r != REC_NONE)
         rec_cnt_r <= rec_cnt_r - 8'h01;
   end

   // internal transfer time on a memory read
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         xfer_cnt_r <= REC_NONE;
      else if (go && mem_read)
         xfer_cnt_r <= REC_RD_XFER - 8'h01;
      else if (xfer_cnt_r != REC_NONE)
         xfer_cnt_r <= xfer_cnt_r - 8'h01;
   end

   // wait low until the access is served; busy high until its recovery is over
   assign bus.wait_request_n = !(strobe_on && state_r != ST_SERVE);
   assign bus.interface_busy = go || (rec_cnt_r != REC_NONE)
                               || state_r == ST_HOLD || state_r == ST_XFER;

   // memory array has no reset; contents are undefined until written
   always_ff @(posedge clk_in) begin
      if (go && is_write && in_mem(pin_r.addr))
         mem[pin_r.addr] <= pin_r.data;
      if (cmd_exec && cmd_op == OP_WRITE) begin
         mem[cmd_addr] <= io_lo_r;
         mem[cmd_addr_next] <= io_hi_r;
      end
   end

   // memory reads go through the indirect buffer, away from the receiver
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         ind_buf_r <= 8'h00;
      else if (go && mem_read)
         ind_buf_r <= mem[pin_r.addr];
   end

   // read command places its result in the io buffer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         io_lo_r <= 8'h00;
         io_hi_r <= 8'h00;
      end else if (cmd_exec && cmd_op == OP_READ) begin
         io_lo_r <= mem[cmd_addr];
         io_hi_r <= mem[cmd_addr_next];
      end else if (go && is_write && pin_r.addr == OFF_IOBUF_LO) begin
         io_lo_r <= pin_r.data;
      end else if (go && is_write && pin_r.addr == OFF_IOBUF_HI) begin
         io_hi_r <= pin_r.data;
      end
   end

   // command byte alternates low then high; the high byte executes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_lo_r <= 8'h00;
         cmd_phase_r <= 1'b0;
         last_op_r <= 4'h0;
         run_r <= 1'b0;
      end else if (go && is_write && pin_r.addr == OFF_STATUS_HI_CMD) begin
         cmd_phase_r <= !cmd_phase_r;
         if (!cmd_phase_r)
            cmd_lo_r <= pin_r.data;
         else begin
            last_op_r <= cmd_op;
            if (cmd_op == OP_START)
               run_r <= 1'b1;
            else if (cmd_op == OP_STOP)
               run_r <= 1'b0;
         end
      end
   end

   // transmit word; valid pulses when the high byte completes it
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_word_r <= 16'h0000;
         tx_valid_r <= 1'b0;
         tx_loaded_r <= 1'b0;
      end else begin
         tx_valid_r <= go && is_write && pin_r.addr == OFF_FIFO_HI;
         if (go && is_write && pin_r.addr == OFF_FIFO_LO)
            tx_word_r[7:0] <= pin_r.data;
         if (go && is_write && pin_r.addr == OFF_FIFO_HI) begin
            tx_word_r[15:8] <= pin_r.data;
            tx_loaded_r <= 1'b1;
         end
      end
   end

   // raw receive samples; only a window of the line, no framing here
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rx_shift_r <= 16'h0000;
      else
         rx_shift_r <= {rx_shift_r[14:0], serial_level};
   end

   // status bytes
   always_comb begin
      status_lo = 8'h00;
      status_lo[ST_BUSY] = bus.interface_busy;
      status_lo[ST_RUN] = run_r;
      status_lo[ST_SERIAL] = serial_level;
      status_lo[ST_TX_LOADED] = tx_loaded_r;
      status_hi = {4'h0, last_op_r};
      status_hi[STH_MODE_HI] = pin_r.mode_hi;
      status_hi[STH_MODE_LO] = pin_r.mode_lo;
   end

   // read data; the io buffer answers at once
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         read_data_r <= 8'h00;
      else if (state_r == ST_XFER && xfer_cnt_r == REC_NONE)
         read_data_r <= ind_buf_r;
      else if (go && !is_write) begin
         case (pin_r.addr)
            OFF_STATUS_LO: read_data_r <= status_lo;
            OFF_STATUS_HI_CMD: read_data_r <= status_hi;
            OFF_IOBUF_LO: read_data_r <= io_lo_r;
            OFF_IOBUF_HI: read_data_r <= io_hi_r;
            OFF_FIFO_LO: read_data_r <= rx_shift_r[7:0];
            OFF_FIFO_HI: read_data_r <= rx_shift_r[15:8];
            default: read_data_r <= 8'h00;
         endcase
      end
   end

   // drive the data lines only while a read is being served
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         oe_r <= 1'b0;
      else
         oe_r <= strobe_on && !pin_r.rd_n && state_nxt == ST_SERVE;
   end

   assign bus.dev_data = read_data_r;
   assign bus.dev_data_oe = oe_r;
   assign run_out = run_r;
   assign tx_word_out = tx_word_r;
   assign tx_valid_out = tx_valid_r;
endmodule
`default_nettype wire

// ---- verilog/host_port_ctrl.sv ----
// host end: Avalon-MM slave that runs paced cycles on the parallel host bus
`timescale 1ns/1ps
`default_nettype none
module host_port_ctrl
   import host_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   host_port_if.host bus,
   input wire logic [11:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_SETUP = 6'b000010,
      H_STROBE = 6'b000100,
      H_RELEASE = 6'b001000,
      H_GAP = 6'b010000,
      H_DONE = 6'b100000
   } host_state_t;

   host_sample_t raw;
   host_sample_t s1_r;
   host_sample_t s2_r;
   host_sample_t s3_r;
   host_sample_t pin_r;
   host_state_t state_r;
   logic [7:0] cnt_r;
   logic [8:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] hi_byte_r;
   logic second_r;
   logic is_wr_r;
   logic [7:0] rdata_r;
   logic [31:0] local_rd;
   logic [9:0] idx;

   // spacing the host keeps after each access kind
   function automatic logic [7:0] gap(input logic wr, input logic [8:0] a,
                                      input logic more);
      logic [7:0] g;
      g = REC_RD;
      if (wr) begin
         // write command low byte; after the high byte
         if (a == OFF_STATUS_HI_CMD)
            g = more ? REC_CMD_WR : REC_CMD_AFTER;
         else if (a >= OFF_IOBUF_LO && a <= OFF_FIFO_HI)
            g = REC_WR_BUF;
         else if (a >= OFF_MEM_FIRST)
            g = REC_WR_MEM;
      end else if (a == OFF_IOBUF_LO || a == OFF_IOBUF_HI) begin
         g = REC_NONE;
      end else begin
         g = REC_RD;
      end
      return g;
   endfunction

   assign idx = avs_address_in[11:2];

   // three-stage synchronisers on the device outputs
   assign raw = {bus.wait_request_n, bus.interface_busy, bus.data_bus};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= '1;
         s2_r <= '1;
         s3_r <= '1;
         pin_r <= '1;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
      end
   end

   // local status word
   always_comb begin
      local_rd = 32'h0000_0000;
      if (idx == AV_IDX_STATUS) begin
         local_rd[AV_ST_BUSY] = pin_r.busy;
         local_rd[AV_ST_WAIT] = !pin_r.wait_n;
      end
   end

   // bus cycle sequencer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= H_IDLE;
         cnt_r <= REC_NONE;
         addr_r <= 9'h000;
         wdata_r <= 8'h00;
         hi_byte_r <= 8'h00;
         second_r <= 1'b0;
         is_wr_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         case (state_r)
            H_IDLE: begin
               cnt_r <= HOST_SETUP_CYC;
               if (avs_read_in || avs_write_in) begin
                  is_wr_r <= avs_write_in;
                  wdata_r <= avs_writedata_in[7:0];
                  if (idx < AV_IDX_STATUS) begin
                     addr_r <= idx[8:0];
                     state_r <= H_SETUP;
                  end else if (idx == AV_IDX_CMD16 && avs_write_in) begin
                     // low byte goes out first, high byte held back
                     addr_r <= OFF_STATUS_HI_CMD;
                     hi_byte_r <= avs_writedata_in[15:8];
                     second_r <= 1'b1;
                     state_r <= H_SETUP;
                  end else begin
                     rdata_r <= local_rd[7:0];
                     state_r <= H_DONE;
                  end
               end
            end
            H_SETUP: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  cnt_r <= HOST_STROBE_MIN;
                  state_r <= H_STROBE;
               end
            end
            H_STROBE: begin
               if (cnt_r != REC_NONE)
                  cnt_r <= cnt_r - 8'h01;
               else if (pin_r.wait_n) begin
                  // device released wait; read data are taken at the end of release
                  cnt_r <= HOST_RELEASE_MIN;
                  state_r <= H_RELEASE;
               end
            end
            H_RELEASE: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  // synced data lag the lines by four cycles; a short wait pulse is
                  // never seen here, so data are only safe late, before the drop
                  if (!is_wr_r)
                     rdata_r <= pin_r.data;
                  cnt_r <= gap(is_wr_r, addr_r, second_r);
                  state_r <= H_GAP;
               end
            end
            H_GAP: begin
               if (cnt_r != REC_NONE)
                  cnt_r <= cnt_r - 8'h01;
               // also poll busy before the next access
               else if (!pin_r.busy) begin
                  if (second_r) begin
                     second_r <= 1'b0;
                     wdata_r <= hi_byte_r;
                     cnt_r <= HOST_SETUP_CYC;
                     state_r <= H_SETUP;
                  end else
                     state_r <= H_DONE;
               end
            end
            H_DONE: state_r <= H_IDLE;
            default: state_r <= H_IDLE;
         endcase
      end
   end

   // buffer bytes go out in whatever order software writes them
   assign bus.cs_n = !(state_r == H_SETUP || state_r == H_STROBE);
   assign bus.rd_n = !(state_r == H_STROBE && !is_wr_r);
   assign bus.wr_n = !(state_r == H_STROBE && is_wr_r);
   assign bus.addr = addr_r;
   assign bus.host_data = wdata_r;
   assign bus.host_data_oe = is_wr_r && (state_r == H_SETUP || state_r == H_STROBE);
   assign bus.host_mode_sel_hi = 1'b1;
   assign bus.host_mode_sel_lo = 1'b1;
   assign avs_readdata_out = {24'h000000, rdata_r};
   assign avs_waitrequest_out = (state_r != H_DONE);
endmodule
`default_nettype wire

// ---- bench/host_port_monitor.sv ----
// concurrent checks on the parallel host bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module host_port_monitor (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic [8:0] addr,
   input wire logic dev_data_oe,
   input wire logic wait_request_n,
   input wire logic interface_busy
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_idle; cs_n [*8] |-> wait_request_n; endproperty
   a_idle: assert property (p_idle) else $error("wait held on idle bus");
   // io buffer reads recover at once, so their busy is a single cycle
   property p_hold;
      $rose(interface_busy) && !(!rd_n && addr[8:1] == 8'h02) |-> interface_busy [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("busy too short");
   // a held access must still be served within a bounded time
   property p_bound; $fell(wait_request_n) |-> ##[1:80] wait_request_n; endproperty
   a_bound: assert property (p_bound) else $error("wait never released");
   property p_cause; $fell(wait_request_n) |-> !cs_n; endproperty
   a_cause: assert property (p_cause) else $error("wait without access");
   property p_go; $rose(interface_busy) |-> !cs_n; endproperty
   a_go: assert property (p_go) else $error("busy without access");
   property p_drive; $rose(dev_data_oe) |-> !cs_n && !rd_n && wait_request_n; endproperty
   a_drive: assert property (p_drive) else $error("data driven outside read");
   // a memory read must have had wait low ten cycles before its data are driven
   property p_xfer;
      $rose(dev_data_oe) && addr >= 9'h078 |-> !$past(wait_request_n, 10);
   endproperty
   a_xfer: assert property (p_xfer) else $error("memory read without wait");
   property p_iobuf; dev_data_oe && addr[8:1] == 8'h02 |-> !interface_busy; endproperty
   a_iobuf: assert property (p_iobuf) else $error("io buffer read paced");
endmodule
`default_nettype wire

// ---- bench/cpu_host_access_timing_tb.sv ----
// self-checking bench joining the host controller and the device
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, s); end end
module cpu_host_access_timing_tb;
   import host_port_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ser_a = 1'b0;
   logic ser_b = 1'b0;
   logic [11:0] av_addr = 12'h000;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [31:0] av_q;
   logic av_wait;
   logic run;
   logic [15:0] txw;
   logic txv;
   logic [31:0] q;
   int errors = 0;
   int cmp_count = 0;
   int mem[512];
   int io[2];
   int a;
   int tx_pulses = 0;
   // count one-cycle transmit strobes
   always @(posedge clk_in) begin
      if (txv === 1'b1)
         tx_pulses++;
   end
   host_port_if hp();
   host_port_device i_host_port_device(.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(hp),
      .serial_in_first_in(ser_a), .serial_in_second_in(ser_b), .run_out(run),
      .tx_word_out(txw), .tx_valid_out(txv));
   host_port_ctrl i_host_port_ctrl(.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(hp),
      .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
      .avs_writedata_in(av_wd), .avs_readdata_out(av_q), .avs_waitrequest_out(av_wait));
   host_port_monitor i_host_port_monitor(.clk_in(clk_in), .rst_n_in(rst_n_in),
      .cs_n(hp.cs_n), .rd_n(hp.rd_n), .addr(hp.addr), .dev_data_oe(hp.dev_data_oe),
      .wait_request_n(hp.wait_request_n), .interface_busy(hp.interface_busy));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic print_verdict();
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [11:0] ba(input int d);
      return {1'b0, 9'(d), 2'b00};
   endfunction
   // one bus cycle; the request stands until waitrequest is sampled low
   task automatic av(input logic w, input logic [11:0] ad, input int d);
      int n;
      @(posedge clk_in);
      av_addr <= ad;
      av_wd <= 32'(d);
      av_rd <= !w;
      av_wr <= w;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (av_wait !== 1'b0 && n < 500);
      q = av_q;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (n >= 500) begin
         errors++;
         print_verdict();
      end
   endtask
   initial begin
      void'($urandom(32'h7839587c));
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // serial level seen through either input pin
      for (int p = 0; p < 3; p++) begin
         ser_a <= (p == 0);
         ser_b <= (p == 1);
         av(1'b0, ba(0), 0);
         `CHK("serial", p < 2, q[ST_SERIAL])
      end
      // direct memory access at both ends of the area, back to back
      for (int i = 0; i < 2; i++) begin
         a = i ? 'h1ff : 'h078;
         mem[a] = $urandom_range(255);
         av(1'b1, ba(a), mem[a]);
         av(1'b0, ba(a), 0);
         `CHK("mem", 8'(mem[a]), q[7:0])
      end
      // write command, buffer loaded high byte first
      io[1] = $urandom_range(255);
      io[0] = $urandom_range(255);
      av(1'b1, ba(5), io[1]);
      av(1'b1, ba(4), io[0]);
      mem['h100] = io[0];
      mem['h101] = io[1];
      av(1'b1, 12'h804, 'h2100);
      av(1'b1, ba(4), io[0] ^ 255);
      av(1'b1, ba(5), io[1] ^ 255);
      for (int i = 0; i < 2; i++) begin
         av(1'b0, ba('h100 + i), 0);
         `CHK("wcmd", 8'(mem['h100 + i]), q[7:0])
      end
      // read command refills the buffer, read back in reverse order
      av(1'b1, 12'h804, 'h1100);
      for (int i = 1; i >= 0; i--) begin
         av(1'b0, ba(4 + i), 0);
         `CHK("rcmd", 8'(mem['h100 + i]), q[7:0])
      end
      io[0] = $urandom_range(255);
      io[1] = $urandom_range(255);
      av(1'b1, ba(6), io[0]);
      av(1'b1, ba(7), io[1]);
      `CHK("fifo", 16'(io[1] * 256 + io[0]), txw)
      `CHK("tx_valid", 1, tx_pulses)
      av(1'b1, 12'h804, 'h3000);
      `CHK("run", 1'b1, run)
      av(1'b0, ba(0), 0);
      `CHK("st_run", 1'b1, q[ST_RUN])
      av(1'b1, 12'h804, 'h4000);
      `CHK("stop", 1'b0, run)
      av(1'b0, ba(1), 0);
      `CHK("st_hi", 8'hc4, q[7:0])
      // unmapped place reads as zero
      av(1'b0, 12'h808, 0);
      `CHK("unmapped", 32'h0, q)
      // idle port: neither busy nor wait seen by the host
      av(1'b0, 12'h800, 0);
      `CHK("host_st", 32'h0, q)
      print_verdict();
   end
endmodule
`default_nettype wire
